// ---- spdif_regs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef SPDIF_REGS_SVH
`define SPDIF_REGS_SVH
// ==========================================================
// Register offsets
`define LOCK_STATUS_ADDR 16'hf600
`define RX_CTRL_ADDR 16'hf601
`define RX_DECODE_ADDR 16'hf602
`define RX_COMPR_ADDR 16'hf603
`define AUX_ENABLE_ADDR 16'hf608
`define RX_CS_LEFT_BASE 16'hf610
`define RX_CS_RIGHT_BASE 16'hf620
`define TX_ENABLE_ADDR 16'hf690
`define TX_CTRL_ADDR 16'hf691
`define TX_AUXSRC_ADDR 16'hf69f
`define TX_CS_LEFT_BASE 16'hf6a0
`define TX_CS_RIGHT_BASE 16'hf6b0
`define CS_WORDS 4'hc
// ==========================================================
// Field positions and reset values
`define AUX_FIELD_MSB 3
`define WORD_LEN_24 2'h0
`define WORD_LEN_20 2'h1
`define WORD_LEN_16 2'h2
`define CTRL_RESET 16'h0000
// ==========================================================
// Timing
`define CLK_PERIOD_NS 5
`define RX_TIMEOUT_NS 4000
`define RX_TIMEOUT_CYC (`RX_TIMEOUT_NS / `CLK_PERIOD_NS)
`define LOCK_SUBFRAMES 3'h4
`define BLOCK_FRAMES 8'hc0
`define TDM_HALF_STEPS 15'h0200
`define PRE_B 8'he8
`define PRE_M 8'he2
`define PRE_W 8'he4
`endif

// ---- spdif_pkg.sv ----
// Types shared by the receiver and top
package spdif_pkg;
  typedef enum logic [1:0] {PRE_B_T, PRE_M_T, PRE_W_T} preamble_type;
  typedef enum {RX_HUNT, RX_PRE, RX_BITS} rx_state_type;
  typedef logic [1:0] word_len_type;
endpackage

// ---- subframe_if.sv ----
// Carrier for one decoded subframe from the line decoder to the top
`timescale 1ns/1ps
interface subframe_if;
  logic valid;
  logic isLeft;
  logic blockStart;
  logic [23:0] audio;
  logic vBit;
  logic uBit;
  logic cBit;
  logic pBit;
  logic locked;
  modport source (output valid, isLeft, blockStart, audio, vBit, uBit, cBit, pBit, locked);
  modport sink (input valid, isLeft, blockStart, audio, vBit, uBit, cBit, pBit, locked);
endinterface

// ---- spdif_bmc_rx.sv ----
// Biphase-mark line decoder with all-digital pulse-width clock recovery
`timescale 1ns/1ps
`include "spdif_regs.svh"
module spdif_bmc_rx (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Synchronised line level
  input wire logic lineIn,
  // Decoded subframes
  subframe_if.source sf
);
  logic lineD_r;
  logic [11:0] cnt_r;
  logic [11:0] unit_r;
  logic [11:0] len;
  logic edgeSeen;
  logic isShort;
  logic isMid;
  logic timeout;
  logic [1:0] cls;
  spdif_pkg::rx_state_type state_r;
  logic [3:0] units_r;
  logic [3:0] unitsSum;
  logic firstPre_r;
  spdif_pkg::preamble_type pre_r;
  logic half_r;
  logic [4:0] bitCnt_r;
  logic [27:0] shift_r;
  logic [2:0] good_r;
  logic parityOk;

  // ==========================================================
  // Pulse measurement and classification
  assign edgeSeen = lineIn ^ lineD_r;
  assign len = cnt_r + 12'h001;
  assign isShort = {len, 1'b0} < (unit_r * 3'h3);
  assign isMid = {len, 1'b0} < (unit_r * 3'h5);
  assign cls = isShort ? 2'h1 : (isMid ? 2'h2 : 2'h3);
  assign timeout = cnt_r >= 12'(`RX_TIMEOUT_CYC);
  assign unitsSum = units_r + {2'h0, cls};
  assign parityOk = ~^shift_r;

  always_ff @(posedge clk)
    if (!rst_n || edgeSeen)
      cnt_r <= 12'h000;
    else if (!timeout)
      cnt_r <= cnt_r + 12'h001;

  always_ff @(posedge clk)
    if (!rst_n)
      lineD_r <= 1'b0;
    else
      lineD_r <= lineIn;

  // Unit tracks the shortest pulse; long runs pull it up so any rate re-acquires
  always_ff @(posedge clk)
    if (!rst_n || timeout)
      unit_r <= 12'hfff;
    else if (edgeSeen)
    begin
      if (len < unit_r)
        unit_r <= len;
      else if (cls == 2'h1)
        unit_r <= 12'((unit_r * 3'h3 + len) >> 2);
      else if (len > {unit_r[9:0], 2'h0})
        unit_r <= len >> 1;
    end

  // ==========================================================
  // Preamble and data cell decoding
  always_ff @(posedge clk)
  begin
    if (!rst_n || timeout)
    begin
      state_r <= spdif_pkg::RX_HUNT;
      good_r <= 3'h0;
      sf.valid <= 1'b0;
      sf.locked <= 1'b0;
      units_r <= 4'h0;
      firstPre_r <= 1'b0;
      pre_r <= spdif_pkg::PRE_M_T;
      half_r <= 1'b0;
      bitCnt_r <= 5'h0;
      shift_r <= 28'h0;
      sf.isLeft <= 1'b0;
      sf.blockStart <= 1'b0;
      sf.audio <= 24'h0;
      {sf.pBit, sf.cBit, sf.uBit, sf.vBit} <= 4'h0;
    end
    else
    begin
      sf.valid <= 1'b0;
      if (edgeSeen)
        unique case (state_r)
          spdif_pkg::RX_HUNT:
            if (cls == 2'h3)
            begin
              state_r <= spdif_pkg::RX_PRE;
              units_r <= 4'h3;
              firstPre_r <= 1'b1;
            end
          spdif_pkg::RX_PRE:
          begin
            firstPre_r <= 1'b0;
            units_r <= unitsSum;
            if (firstPre_r)
              pre_r <= (cls == 2'h1) ? spdif_pkg::PRE_B_T :
                       (cls == 2'h2) ? spdif_pkg::PRE_W_T : spdif_pkg::PRE_M_T;
            if (unitsSum == 4'h8)
            begin
              state_r <= spdif_pkg::RX_BITS;
              bitCnt_r <= 5'h0;
              half_r <= 1'b0;
            end
            else if (unitsSum > 4'h8)
            begin
              state_r <= spdif_pkg::RX_HUNT;
              good_r <= 3'h0;
              sf.locked <= 1'b0;
            end
          end
          spdif_pkg::RX_BITS:
            if (cls == 2'h3 || (cls == 2'h2 && half_r))
            begin
              state_r <= spdif_pkg::RX_HUNT;
              good_r <= 3'h0;
              sf.locked <= 1'b0;
            end
            else if (cls == 2'h1 && !half_r)
              half_r <= 1'b1;
            else
            begin
              half_r <= 1'b0;
              shift_r <= {cls == 2'h1, shift_r[27:1]};
              bitCnt_r <= bitCnt_r + 5'h1;
              if (bitCnt_r == 5'h1b)
                state_r <= spdif_pkg::RX_HUNT;
            end
        endcase
      // Word complete: checked on the cycle after the last cell
      if (state_r == spdif_pkg::RX_HUNT && bitCnt_r == 5'h1c)
      begin
        bitCnt_r <= 5'h0;
        if (parityOk)
        begin
          sf.valid <= 1'b1;
          sf.isLeft <= pre_r != spdif_pkg::PRE_W_T;
          sf.blockStart <= pre_r == spdif_pkg::PRE_B_T;
          sf.audio <= shift_r[23:0];
          {sf.pBit, sf.cBit, sf.uBit, sf.vBit} <= shift_r[27:24];
          if (good_r != `LOCK_SUBFRAMES)
            good_r <= good_r + 3'h1;
          else
            sf.locked <= 1'b1;
        end
        else
        begin
          good_r <= 3'h0;
          sf.locked <= 1'b0;
        end
      end
    end
  end
endmodule // spdif_bmc_rx

// ---- spdif_bmc_tx.sv ----
// Biphase-mark line encoder, one frame per core sample strobe
`timescale 1ns/1ps
`include "spdif_regs.svh"
module spdif_bmc_tx (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Core samples
  input wire logic enable,
  input wire logic strobe,
  input wire logic [23:0] leftIn,
  input wire logic [23:0] rightIn,
  // Non-audio bits for the frame being started
  input wire logic cBitL,
  input wire logic cBitR,
  input wire logic uBit,
  // Frame position and line
  output logic [7:0] frameIdx,
  output logic lineOut
);
  logic [17:0] perCnt_r;
  logic [10:0] halfLen_r;
  logic [10:0] halfTmr_r;
  logic [6:0] halfIdx_r;
  logic running_r;
  logic startLvl_r;
  logic [27:0] wordL_r;
  logic [27:0] wordR_r;
  logic blockFirst_r;
  logic tick;
  logic lvl0;
  logic [27:0] word;
  logic [7:0] pat;
  logic dataBit;
  logic nxt;
  logic [4:0] slot;

  // ==========================================================
  // Half-cell timing from the measured core sample period
  assign tick = running_r && halfTmr_r == 11'h000;
  assign slot = halfIdx_r[5:1];
  assign lvl0 = (halfIdx_r[5:0] == 6'h00) ? lineOut : startLvl_r;
  assign word = halfIdx_r[6] ? wordR_r : wordL_r;
  assign pat = halfIdx_r[6] ? `PRE_W : (blockFirst_r ? `PRE_B : `PRE_M);
  assign dataBit = word[5'(slot - 5'h4)];
  assign nxt = (slot < 5'h4) ? (pat[3'h7 - halfIdx_r[2:0]] ^ lvl0) :
               (!halfIdx_r[0] ? ~lineOut : (dataBit ? ~lineOut : lineOut));

  always_ff @(posedge clk)
    if (!rst_n || strobe)
      perCnt_r <= 18'h0;
    else if (perCnt_r != 18'h3ffff)
      perCnt_r <= perCnt_r + 18'h1;

  // One frame carries 128 half cells at the core rate
  always_ff @(posedge clk)
    if (!rst_n)
      halfLen_r <= 11'h001;
    else if (strobe)
      halfLen_r <= (perCnt_r[17:7] == 11'h0) ? 11'h001 : perCnt_r[17:7];

  // ==========================================================
  // Frame sequencing
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      running_r <= 1'b0;
      halfTmr_r <= 11'h000;
      halfIdx_r <= 7'h00;
      lineOut <= 1'b0;
      startLvl_r <= 1'b0;
      frameIdx <= 8'h00;
      blockFirst_r <= 1'b0;
      wordL_r <= 28'h0;
      wordR_r <= 28'h0;
    end
    else if (strobe && enable)
    begin
      running_r <= 1'b1;
      halfTmr_r <= 11'h000;
      halfIdx_r <= 7'h00;
      blockFirst_r <= frameIdx == 8'h00;
      frameIdx <= (frameIdx == `BLOCK_FRAMES - 8'h01) ? 8'h00 : frameIdx + 8'h01;
      // Even parity over slots 4..31 so each subframe ends on its start level
      wordL_r <= {^{cBitL, uBit, leftIn}, cBitL, uBit, 1'b0, leftIn};
      wordR_r <= {^{cBitR, uBit, rightIn}, cBitR, uBit, 1'b0, rightIn};
    end
    else if (tick)
    begin
      lineOut <= nxt;
      if (halfIdx_r[5:0] == 6'h00)
        startLvl_r <= lineOut;
      halfIdx_r <= halfIdx_r + 7'h01;
      halfTmr_r <= halfLen_r - 11'h001;
      if (halfIdx_r == 7'h7f)
        running_r <= 1'b0;
    end
    else if (running_r)
      halfTmr_r <= halfTmr_r - 11'h001;
  end
endmodule // spdif_bmc_tx

// ---- spdif_rx_tx_aux_tdm.sv ----
// S/PDIF receiver, transmitter and auxiliary eight-slot TDM output
// Contract
// - Receiver decodes two channels from one biphase-mark input pin.
// - Transmitter sends two channels biphase-mark coded on one output pin.
// - Receive and transmit word length independently select 16, 20 or 24 bits.
// - Receiver decodes any sample rate from 18 kHz to 192 kHz.
// - Only the consumer channel format is handled.
// - Receiver stores user, status, validity, frame clock and block start in registers.
// - Clock recovery is fully digital and tolerates the stated jitter.
// - Transmitter takes two core channels and sends frames at core rate.
// - Transmitted non-audio bits come from receiver copy or transmit registers; here only status bits do, user is receiver copy or 0, validity is 0.
// - Aux field nonzero sends received data as eight-slot TDM frame.
// - In aux mode recovered bit and frame clocks are driven as master.
// - Bit clock is 256 times sample rate; frame clock 50% duty.
// - Slots 0 and 4: eight zeros then 24-bit left or right audio.
// - Slots 1 and 5: 28 zeros then parity, validity, user, status.
// - Slot 2: 30 zeros, compression type bit, audio type bit.
// - Slots 3 and 6 empty; slot 7: 31 zeros then block start.
// - Lock state is readable in the lock status register.
`timescale 1ns/1ps
`include "spdif_regs.svh"
module spdif_rx_tx_aux_tdm (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Line pins
  input wire logic rxLinePin,
  output logic txLinePin,
  // Auxiliary TDM pins
  output logic outputBitClockPin,
  output logic outputBitClockOe,
  output logic outputFrameClockPin,
  output logic outputFrameClockOe,
  output logic auxDataPin,
  // Core side
  input wire logic txStrobe,
  input wire logic [23:0] txLeft,
  input wire logic [23:0] txRight,
  output logic rxStrobe,
  output logic [23:0] rxLeft,
  output logic [23:0] rxRight,
  // Control port
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  output logic regRdValid
);
  subframe_if sf ();
  logic rxMeta_r;
  logic rxSync_r;
  spdif_pkg::word_len_type rxWordLen_r;
  spdif_pkg::word_len_type txWordLen_r;
  logic [3:0] auxOutputSelect_r;
  logic txEn_r;
  logic txAuxSrc_r;
  logic comprType_r;
  logic [15:0] rxCsL [12];
  logic [15:0] rxCsR [12];
  logic [15:0] txCsL [12];
  logic [15:0] txCsR [12];
  logic [7:0] rxFrm_r;
  logic [3:0] bitsL_r;
  logic [3:0] bitsR_r;
  logic blockSeen_r;
  logic lastU_r;
  logic [13:0] perCnt_r;
  logic [13:0] per_r;
  logic [13:0] acc_r;
  logic [7:0] bitCnt_r;
  logic [23:0] snapL_r;
  logic [23:0] snapR_r;
  logic [3:0] snapBL_r;
  logic [3:0] snapBR_r;
  logic [1:0] snapType_r;
  logic snapBlock_r;
  logic [7:0] txFrame;
  logic txLine;

  // ==========================================================
  // Pin synchroniser and line codecs
  always_ff @(posedge clk)
    if (!rst_n)
    begin
      rxMeta_r <= 1'b0;
      rxSync_r <= 1'b0;
    end
    else
    begin
      rxMeta_r <= rxLinePin;
      rxSync_r <= rxMeta_r;
    end

  spdif_bmc_rx u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .lineIn(rxSync_r),
    .sf(sf.source)
  );

  wire [3:0] txWord = txFrame[7:4];
  wire [3:0] txBit = txFrame[3:0];
  wire txCbitL = txAuxSrc_r ? rxCsL[txWord][txBit] : txCsL[txWord][txBit];
  wire txCbitR = txAuxSrc_r ? rxCsR[txWord][txBit] : txCsR[txWord][txBit];
  wire txUbit = txAuxSrc_r & lastU_r;

  spdif_bmc_tx u_tx (
    .clk(clk),
    .rst_n(rst_n),
    .enable(txEn_r),
    .strobe(txStrobe),
    .leftIn(maskLen(txLeft, txWordLen_r)),
    .rightIn(maskLen(txRight, txWordLen_r)),
    .cBitL(txCbitL),
    .cBitR(txCbitR),
    .uBit(txUbit),
    .frameIdx(txFrame),
    .lineOut(txLine)
  );

  always_ff @(posedge clk)
    if (!rst_n)
      txLinePin <= 1'b0;
    else
      txLinePin <= txEn_r & txLine;

  // Clear the low bits that a shorter word does not carry
  function automatic logic [23:0] maskLen(input logic [23:0] w, input logic [1:0] len);
    unique case (len)
      `WORD_LEN_20: maskLen = {w[23:4], 4'h0};
      `WORD_LEN_16: maskLen = {w[23:8], 8'h00};
      default: maskLen = w;
    endcase
  endfunction

  // ==========================================================
  // Received subframe capture
  wire rxTake = sf.valid && sf.locked;
  wire [7:0] rxFrmNow = sf.blockStart ? 8'h00 : rxFrm_r;

  always_ff @(posedge clk)
  begin
    rxStrobe <= 1'b0;
    if (!rst_n)
    begin
      rxFrm_r <= 8'h00;
      rxLeft <= 24'h0;
      rxRight <= 24'h0;
      bitsL_r <= 4'h0;
      bitsR_r <= 4'h0;
      blockSeen_r <= 1'b0;
      lastU_r <= 1'b0;
    end
    else if (rxTake)
    begin
      lastU_r <= sf.uBit;
      if (sf.isLeft)
      begin
        rxLeft <= maskLen(sf.audio, rxWordLen_r);
        bitsL_r <= {sf.pBit, sf.vBit, sf.uBit, sf.cBit};
        blockSeen_r <= sf.blockStart;
        rxFrm_r <= rxFrmNow;
        rxCsL[rxFrmNow[7:4]][rxFrmNow[3:0]] <= sf.cBit;
      end
      else
      begin
        // Right half closes the frame: the virtual frame clock edge
        rxRight <= maskLen(sf.audio, rxWordLen_r);
        bitsR_r <= {sf.pBit, sf.vBit, sf.uBit, sf.cBit};
        rxCsR[rxFrm_r[7:4]][rxFrm_r[3:0]] <= sf.cBit;
        rxStrobe <= 1'b1;
        rxFrm_r <= (rxFrm_r == `BLOCK_FRAMES - 8'h01) ? 8'h00 : rxFrm_r + 8'h01;
      end
    end
  end

  // ==========================================================
  // Recovered sample period and bit clock synthesis
  wire auxOn = auxOutputSelect_r != 4'h0;
  wire leftTick = rxTake && sf.isLeft;
  wire [14:0] accSum = {1'b0, acc_r} + `TDM_HALF_STEPS;
  wire accWrap = accSum >= {1'b0, per_r};
  wire fallEdge = accWrap && outputBitClockPin;
  wire [7:0] bitNext = bitCnt_r + 8'h01;

  always_ff @(posedge clk)
    if (!rst_n || leftTick)
      perCnt_r <= 14'h0;
    else if (perCnt_r != 14'h3fff)
      perCnt_r <= perCnt_r + 14'h1;

  always_ff @(posedge clk)
    if (!rst_n)
      per_r <= 14'h3fff;
    else if (leftTick)
      per_r <= perCnt_r + 14'h1;

  // 512 half periods per sample period, spread evenly by the accumulator
  always_ff @(posedge clk)
    if (!rst_n || !auxOn || !sf.locked)
    begin
      acc_r <= 14'h0;
      outputBitClockPin <= 1'b0;
      outputFrameClockPin <= 1'b0;
      bitCnt_r <= 8'hff;
      auxDataPin <= 1'b0;
    end
    else if (accWrap)
    begin
      acc_r <= 14'(accSum - {1'b0, per_r});
      outputBitClockPin <= ~outputBitClockPin;
      if (fallEdge)
      begin
        bitCnt_r <= bitNext;
        outputFrameClockPin <= bitNext[7];
        auxDataPin <= slotBit(bitNext);
      end
    end
    else
      acc_r <= accSum[13:0];

  always_ff @(posedge clk)
    if (!rst_n)
    begin
      outputBitClockOe <= 1'b0;
      outputFrameClockOe <= 1'b0;
    end
    else
    begin
      outputBitClockOe <= auxOn;
      outputFrameClockOe <= auxOn;
    end

  // Fields are frozen for a whole TDM frame so a slot never tears
  always_ff @(posedge clk)
    if (!rst_n)
    begin
      snapL_r <= 24'h0;
      snapR_r <= 24'h0;
      snapBL_r <= 4'h0;
      snapBR_r <= 4'h0;
      snapType_r <= 2'h0;
      snapBlock_r <= 1'b0;
    end
    else if (fallEdge && bitNext == 8'h00)
    begin
      snapL_r <= rxLeft;
      snapR_r <= rxRight;
      snapBL_r <= bitsL_r;
      snapBR_r <= bitsR_r;
      snapType_r <= {comprType_r, rxCsL[0][1]};
      snapBlock_r <= blockSeen_r;
    end

  function automatic logic slotBit(input logic [7:0] pos);
    logic [31:0] w;
    w = 32'h0;
    unique case (pos[7:5])
      3'h0: w = {8'h00, snapL_r};
      3'h1: w = {28'h0, snapBL_r};
      3'h2: w = {30'h0, snapType_r};
      3'h4: w = {8'h00, snapR_r};
      3'h5: w = {28'h0, snapBR_r};
      3'h7: w = {31'h0, snapBlock_r};
      default: w = 32'h0;
    endcase
    slotBit = w[5'h1f - pos[4:0]];
  endfunction

  // ==========================================================
  // Control registers
  wire inRxCsL = regAddr[15:4] == `RX_CS_LEFT_BASE >> 4 && regAddr[3:0] < `CS_WORDS;
  wire inRxCsR = regAddr[15:4] == `RX_CS_RIGHT_BASE >> 4 && regAddr[3:0] < `CS_WORDS;
  wire inTxCsL = regAddr[15:4] == `TX_CS_LEFT_BASE >> 4 && regAddr[3:0] < `CS_WORDS;
  wire inTxCsR = regAddr[15:4] == `TX_CS_RIGHT_BASE >> 4 && regAddr[3:0] < `CS_WORDS;
  wire [15:0] rdMux =
    (regAddr == `LOCK_STATUS_ADDR) ? {15'h0, sf.locked} :
    (regAddr == `RX_CTRL_ADDR) ? {14'h0, rxWordLen_r} :
    (regAddr == `RX_DECODE_ADDR) ? {7'h0, blockSeen_r, bitsR_r, bitsL_r} :
    (regAddr == `RX_COMPR_ADDR) ? {14'h0, comprType_r, rxCsL[0][1]} :
    (regAddr == `AUX_ENABLE_ADDR) ? {12'h0, auxOutputSelect_r} :
    (regAddr == `TX_ENABLE_ADDR) ? {15'h0, txEn_r} :
    (regAddr == `TX_CTRL_ADDR) ? {14'h0, txWordLen_r} :
    (regAddr == `TX_AUXSRC_ADDR) ? {15'h0, txAuxSrc_r} :
    inRxCsL ? rxCsL[regAddr[3:0]] :
    inRxCsR ? rxCsR[regAddr[3:0]] :
    inTxCsL ? txCsL[regAddr[3:0]] :
    inTxCsR ? txCsR[regAddr[3:0]] : 16'h0000;

  always_ff @(posedge clk)
    if (!rst_n)
    begin
      regRdata <= `CTRL_RESET;
      regRdValid <= 1'b0;
      rxWordLen_r <= `WORD_LEN_24;
      txWordLen_r <= `WORD_LEN_24;
      auxOutputSelect_r <= 4'h0;
      txEn_r <= 1'b0;
      txAuxSrc_r <= 1'b0;
      comprType_r <= 1'b0;
    end
    else
    begin
      regRdValid <= regRd;
      regRdata <= regRd ? rdMux : regRdata;
      if (regWr)
      begin
        if (regAddr == `RX_CTRL_ADDR)
          rxWordLen_r <= regWdata[1:0];
        if (regAddr == `TX_CTRL_ADDR)
          txWordLen_r <= regWdata[1:0];
        if (regAddr == `AUX_ENABLE_ADDR)
          auxOutputSelect_r <= regWdata[`AUX_FIELD_MSB:0];
        if (regAddr == `TX_ENABLE_ADDR)
          txEn_r <= regWdata[0];
        if (regAddr == `TX_AUXSRC_ADDR)
          txAuxSrc_r <= regWdata[0];
        if (regAddr == `RX_COMPR_ADDR)
          comprType_r <= regWdata[1];
        if (inTxCsL)
          txCsL[regAddr[3:0]] <= regWdata;
        if (inTxCsR)
          txCsR[regAddr[3:0]] <= regWdata;
      end
    end
endmodule // spdif_rx_tx_aux_tdm

// ---- spdif_rx_tx_aux_tdm_asserts.sv ----
// Port assertions for the S/PDIF block
`timescale 1ns/1ps
module spdif_rx_tx_aux_tdm_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins and core
  input wire logic txLinePin,
  input wire logic outputBitClockPin,
  input wire logic outputBitClockOe,
  input wire logic outputFrameClockOe,
  input wire logic txStrobe,
  input wire logic rxStrobe,
  // Control port
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic regRdValid
);
  logic txOn_r;
  // ====================
  // Shadow of the tx enable bit
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      txOn_r <= 1'b0;
    else if (regWr && regAddr == 16'hf690)
      txOn_r <= regWdata[0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd(a);
    regRd && regAddr == a;
  endsequence
  sequence s_kick;
    txStrobe && txOn_r;
  endsequence
  a_read_valid: assert property (regRd |=> regRdValid)
    else $error("read not answered");
  a_valid_only: assert property (!regRd |=> !regRdValid)
    else $error("stray read valid");
  a_lock_width: assert property (s_rd(16'hf600) |=> regRdata[15:1] == 15'h0)
    else $error("lock status upper bits set");
  a_unmapped_zero: assert property (s_rd(16'h1234) |=> regRdata == 16'h0)
    else $error("unmapped read not zero");
  a_oe_pair: assert property (outputBitClockOe == outputFrameClockOe)
    else $error("clock enables differ");
  a_clk_parked: assert property (!outputBitClockOe |-> !outputBitClockPin)
    else $error("bit clock runs while not driven");
  a_strobe_single: assert property (rxStrobe |=> !rxStrobe)
    else $error("rx strobe longer than one cycle");
  a_tx_silent: assert property (!txOn_r [*4] |-> !txLinePin)
    else $error("tx line active while disabled");
  a_tx_start: assert property (s_kick |-> ##3 $changed(txLinePin))
    else $error("frame did not start three cycles after strobe");
endmodule // spdif_rx_tx_aux_tdm_asserts
bind spdif_rx_tx_aux_tdm spdif_rx_tx_aux_tdm_asserts chk (.*);

// ---- spdif_src_model.sv ----
// Consumer S/PDIF source model driving a biphase-mark line
`timescale 1ns/1ps
`include "spdif_regs.svh"
module spdif_src_model (
  // Control and content
  input wire logic run,
  input wire logic [23:0] left,
  input wire logic [23:0] right,
  input wire logic uBit,
  // Line
  output logic line
);
  logic [7:0] fIdx = 8'h0;
  initial line = 1'b0;
  task automatic half(input logic v);
    line = v;
    #62.5;
  endtask
  // ====================
  // Preamble is relative to the level left behind, then 28 cells
  task automatic sub(input logic [7:0] pre, input logic [23:0] a);
    logic [27:0] d;
    logic lv;
    d = {1'b0, 1'b0, uBit, 1'b0, a};
    d[27] = ^d[26:0];
    lv = line;
    for (int i = 7; i >= 0; i--)
      half(pre[i] ^ lv);
    for (int i = 0; i < 28; i++)
    begin
      half(!line);
      half(line ^ d[i]);
    end
  endtask
  // Line holds its level between runs, as an idle source would
  always
  begin
    if (run)
    begin
      sub(fIdx == 8'h0 ? `PRE_B : `PRE_M, left);
      sub(`PRE_W, right);
      fIdx = fIdx == `BLOCK_FRAMES - 8'h1 ? 8'h0 : fIdx + 8'h1;
    end
    else
      #62.5;
  end
endmodule // spdif_src_model

// ---- tb.sv ----
// Self-checking bench for the S/PDIF receiver, transmitter and aux output
`timescale 1ns/1ps
module tb;
  localparam logic [23:0] SrcL = 24'ha5c381;
  localparam logic [23:0] SrcR = 24'h3c5a0f;
  localparam logic [23:0] TxL = 24'h123456;
  localparam logic [23:0] TxR = 24'hfedcb9;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic run = 1'b0;
  logic loop = 1'b0;
  logic txStrobe = 1'b0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regAddr = 16'h0;
  logic [15:0] regWdata = 16'h0;
  logic srcLine, txLine, bck, bckOe, fck, fckOe, auxData, rxStb, rdValid;
  logic [23:0] rxLeft, rxRight;
  logic [15:0] regRdata, rd;
  logic [255:0] fr, fg;
  int mismatches = 0;
  int checked = 0;
  int sc = 0;
  always #2.5 clk = ~clk;
  always @(negedge clk)
  begin
    sc = (sc == 1536) ? 0 : sc + 1;
    txStrobe <= rst_n && sc == 0;
  end
  spdif_src_model src (.run(run), .left(SrcL), .right(SrcR), .uBit(1'b1), .line(srcLine));
  spdif_rx_tx_aux_tdm dut (.clk(clk), .rst_n(rst_n), .rxLinePin(loop ? txLine : srcLine),
    .txLinePin(txLine), .outputBitClockPin(bck), .outputBitClockOe(bckOe),
    .outputFrameClockPin(fck), .outputFrameClockOe(fckOe), .auxDataPin(auxData),
    .txStrobe(txStrobe), .txLeft(TxL), .txRight(TxR), .rxStrobe(rxStb),
    .rxLeft(rxLeft), .rxRight(rxRight), .regWr(regWr), .regRd(regRd),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRdValid(rdValid));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    regWr = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge clk);
    regWr = 1'b0;
  endtask
  task automatic rdr(input logic [15:0] a);
    @(negedge clk);
    regRd = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRd = 1'b0;
    rd = regRdata;
    check({31'h0, rdValid}, 32'h1);
  endtask
  // ====================
  // Bounded waits: lock, received frames, one aux frame
  task automatic wait_lock();
    int n;
    rd = 16'h0;
    for (n = 0; n < 5000 && rd[0] !== 1'b1; n++)
      rdr(16'hf600);
    check(n < 5000, 32'h1);
    if (n == 5000)
      give_verdict();
  endtask
  task automatic frames(input int k);
    int n;
    repeat (k)
    begin
      for (n = 0; n < 4000 && rxStb !== 1'b1; n++)
        @(negedge clk);
      check(n < 4000, 32'h1);
      if (n == 4000)
        give_verdict();
      @(negedge clk);
    end
  endtask
  task automatic grab();
    int n, k;
    logic pb, pf;
    pf = 1'b0;
    for (n = 0; n < 4000 && !(pf && !fck); n++)
    begin
      pf = fck;
      @(negedge clk);
    end
    check(n < 4000, 32'h1);
    if (n == 4000)
      give_verdict();
    pb = bck;
    k = 0;
    for (n = 0; n < 4000 && k < 256; n++)
    begin
      @(negedge clk);
      if (bck && !pb)
      begin
        fr[255 - k] = auxData;
        fg[255 - k] = fck;
        k++;
      end
      pb = bck;
    end
    check(k, 32'd256);
    if (k != 256)
      give_verdict();
  endtask
  // ====================
  // Scenarios
  task automatic t_reset();
    logic [15:0] a[5] = '{16'hf600, 16'hf601, 16'hf608, 16'hf690, 16'h1234};
    wr(16'hf600, 16'hffff);
    wr(16'h1234, 16'hffff);
    foreach (a[i])
    begin
      rdr(a[i]);
      check({16'h0, rd}, 32'h0);
    end
  endtask
  task automatic t_rx();
    logic [23:0] m[3] = '{24'hffffff, 24'hfffff0, 24'hffff00};
    run = 1'b1;
    wait_lock();
    foreach (m[i])
    begin
      wr(16'hf601, 16'(i));
      frames(2);
      check({8'h0, rxLeft}, {8'h0, SrcL & m[i]});
      check({8'h0, rxRight}, {8'h0, SrcR & m[i]});
    end
    wr(16'hf601, 16'h0);
    rdr(16'hf602);
    check({24'h0, rd[7:0]}, {24'h0, ~^SrcR, 3'b010, ~^SrcL, 3'b010});
  endtask
  task automatic t_aux();
    logic [31:0] e[8] = '{{8'h0, SrcL}, {28'h0, ~^SrcL, 3'b010}, 32'h0, 32'h0,
      {8'h0, SrcR}, {28'h0, ~^SrcR, 3'b010}, 32'h0, 32'h0};
    wr(16'hf608, 16'h0001);
    grab();
    check({31'h0, fckOe}, 32'h1);
    check({30'h0, |fg[255:128], &fg[127:0]}, 32'h1);
    // Bit 0 of slots 2 and 7 depends on stream position
    for (int i = 0; i < 8; i++)
      check(fr[255 - 32 * i -: 32] & ((i % 5 == 2) ? 32'hfffffffe : '1), e[i]);
    wr(16'hf603, 16'h0002);
    grab();
    check(fr[191:160] & 32'hfffffffe, 32'h2);
    wr(16'hf608, 16'h0);
    wr(16'hf603, 16'h0);
    check({31'h0, bckOe}, 32'h0);
  endtask
  task automatic t_tx();
    for (int k = 0; k < 12; k++)
    begin
      wr(16'hf6a0 + 16'(k), 16'h0);
      wr(16'hf6b0 + 16'(k), 16'h0);
    end
    wr(16'hf690, 16'h0001);
    run = 1'b0;
    loop = 1'b1;
    repeat (2000) @(negedge clk);
    wait_lock();
    frames(2);
    check({8'h0, rxLeft}, {8'h0, TxL});
    check({8'h0, rxRight}, {8'h0, TxR});
    rdr(16'hf602);
    check({28'h0, rd[3:0]}, {28'h0, ^TxL, 3'b000});
    wr(16'hf691, 16'h0002);
    frames(3);
    check({8'h0, rxLeft}, {8'h0, TxL & 24'hffff00});
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_rx();
    t_aux();
    t_tx();
    give_verdict();
  end
endmodule // tb
